// ===== rtl/ssp_pkg.sv
// Shared constants, register map and pin carrier for the serial shift port
package ssp_pkg;
    localparam int ADDR_W = 8;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h04;
    localparam logic [7:0] OFS_DATA = 8'h08;
    localparam logic [7:0] OFS_PINS = 8'h0c;
    // port_control_register fields
    localparam int CB_IRQ_EN = 7;
    localparam int CB_ENABLE = 6;
    localparam int CB_LSB_FIRST = 5;
    localparam int CB_CTRL_SEL = 4;
    localparam int CB_IDLE_LEVEL = 3;
    localparam int CB_SAMPLE_PHASE = 2;
    localparam int CB_RATE_HI = 1;
    localparam int CB_RATE_LO = 0;
    // Status fields
    localparam int SB_DONE = 7;
    localparam int SB_WCOL = 6;
    localparam int SB_DOUBLE = 0;
    // Pin configuration fields
    localparam int PB_POWER_GATE = 0;
    localparam int PB_MOSI_DIR = 1;
    localparam int PB_SCK_DIR = 2;
    localparam int PB_SEL_DIR = 3;
    localparam int PB_MISO_DIR = 4;
    localparam int PB_SEL_LEVEL = 5;
    localparam int PINS_W = 6;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [PINS_W-1:0] PINS_RST = 6'h21;
    // Full SCK periods in pclk cycles for each rate select
    localparam int DIV_R0 = 4;
    localparam int DIV_R1 = 16;
    localparam int DIV_R2 = 64;
    localparam int DIV_R3 = 128;
    localparam int BITS = 8;
    localparam logic [4:0] LAST_EDGE = 5'd15;
    // Cycles from a controller sample edge until the reply on its data-in pin can be read:
    // one for the registered clock pin, two for the synchroniser
    localparam int MISO_LAG = 3;

    typedef struct packed {
        logic mosi_o;
        logic mosi_oe;
        logic miso_o;
        logic miso_oe;
        logic sck_o;
        logic sck_oe;
        logic sel_o;
        logic sel_oe;
    } pin_out_t;

    typedef enum logic [1:0] {ST_IDLE, ST_CTRL, ST_TGT} mode_t;
endpackage

// ===== rtl/sync_serial_shift_port.sv
// Full-duplex serial shift port, controller or target, with APB register access
`timescale 1ns/1ps

// Functional notes
// - Controller: writing a data byte starts the clock generator and shifts eight bits.
// - Controller: after one byte the clock stops and the done flag sets.
// - Done flag with interrupt enable raises the interrupt request in both modes.
// - Controller never drives select automatically; software sets its level.
// - Controller software writes another byte or raises select to end a packet.
// - Data goes out on MOSI, back on MISO, both registers exchanging together.
// - Target with select high stays idle, MISO not driven.
// - Target may be loaded while select high; shifting waits for select low.
// - Target sets done flag once a complete byte has shifted.
// - Target may load new transmit data before reading the received byte.
// - Last received byte is kept in a readable receive buffer.
// - Transmit single buffered: no new byte accepted during a shift.
// - Receive double buffered: unread byte is overwritten by the next one.
// - Each pin drives only when its mode is active and its user direction bit is set; a disabled port drives nothing.
// - Port unusable until its power gate bit is cleared.
// - Bit order selectable, LSB first or MSB first.
// - Seven controller clock rates including double speed at half pclk.
// - Write collision flag marks data writes during a transfer.
// - Transfer completion gives a wake pulse for idle sleep.
// - Target: select rising resets shift logic and drops a partial byte.
// - Controller with select input driven low drops to target and sets done.
// - Idle level and sample phase pick modes 0-3; drive and sample opposite edges.
// - Rate bits give /4,/16,/64,/128, doubled by double rate; controller only.
module sync_serial_shift_port
    import ssp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic mosi_i,
    input wire logic miso_i,
    input wire logic sck_i,
    input wire logic sel_n_i,
    output pin_out_t pins,
    output logic irq,
    output logic wake
);
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    pin_out_t pins_ff;
    logic irq_ff;
    logic wake_ff;
    logic [7:0] ctrl_ff;
    logic [PINS_W-1:0] pcfg_ff;
    logic double_ff;
    logic done_ff;
    logic wcol_ff;
    logic armed_ff;
    logic [7:0] shift_ff;
    logic [7:0] rx_buf_ff;
    logic out_bit_ff;
    logic [4:0] edge_ff;
    logic [7:0] div_ff;
    logic sck_gen_ff;
    mode_t state_ff;
    logic [3:0] meta_ff;
    logic [3:0] sync_ff;
    logic sck_prev_ff;
    logic sel_prev_ff;
    logic [7:0] rx_sh_ff;
    logic [MISO_LAG-1:0] lag_smp_ff;
    logic [MISO_LAG-1:0] lag_fin_ff;

    // Two-stage synchronisers for the pin inputs: {sel, sck, miso, mosi}
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_ff <= 4'hf;
            sync_ff <= 4'hf;
        end
        else if (clk_en)
        begin
            meta_ff <= {sel_n_i, sck_i, miso_i, mosi_i};
            sync_ff <= meta_ff;
        end
    end

    wire mosi_s = sync_ff[0];
    wire miso_s = sync_ff[1];
    wire sck_s = sync_ff[2];
    wire sel_s = sync_ff[3];

    // Bus decode
    wire setup_ph = psel && !penable && !pready_ff;
    wire access = psel && penable && pready_ff;
    wire wr = access && pwrite;
    wire rd = access && !pwrite;
    wire hit_ctrl = (paddr == OFS_CTRL);
    wire hit_stat = (paddr == OFS_STAT);
    wire hit_data = (paddr == OFS_DATA);
    wire hit_pins = (paddr == OFS_PINS);
    wire mapped = hit_ctrl || hit_stat || hit_data || hit_pins;

    // Configuration views
    wire gated = pcfg_ff[PB_POWER_GATE];
    wire enabled = ctrl_ff[CB_ENABLE] && !gated;
    wire is_ctrl = ctrl_ff[CB_CTRL_SEL];
    wire lsb_first = ctrl_ff[CB_LSB_FIRST];
    wire idle_lvl = ctrl_ff[CB_IDLE_LEVEL];
    wire phase = ctrl_ff[CB_SAMPLE_PHASE];
    wire [1:0] rate = ctrl_ff[CB_RATE_HI:CB_RATE_LO];
    wire sel_as_input = !pcfg_ff[PB_SEL_DIR];
    wire busy = ((state_ff != ST_IDLE) && (edge_ff != 5'd0 || state_ff == ST_CTRL)) || (|lag_fin_ff);

    // Half SCK period in pclk cycles; a full period of 2 is the double-speed floor
    wire [7:0] full_div = (rate == 2'd0) ? 8'(DIV_R0) :
                          (rate == 2'd1) ? 8'(DIV_R1) :
                          (rate == 2'd2) ? 8'(DIV_R2) : 8'(DIV_R3);
    wire [7:0] half_div = double_ff ? (full_div >> 2) : (full_div >> 1);

    // Edge numbering: even edges lead, odd edges trail; sample parity follows phase
    wire head_bit = lsb_first ? shift_ff[0] : shift_ff[7];
    wire in_bit = is_ctrl ? miso_s : mosi_s;
    wire [7:0] shifted = lsb_first ? {in_bit, shift_ff[7:1]} : {shift_ff[6:0], in_bit};

    // Target edge detect on the synchronised clock
    wire tgt_edge = (state_ff == ST_TGT) && (sck_s != sck_prev_ff);
    wire ctl_edge = (state_ff == ST_CTRL) && (div_ff == 8'd1);
    wire any_edge = tgt_edge || ctl_edge;
    wire sample_edge = any_edge && (edge_ff[0] == phase);
    wire setup_edge = any_edge && (edge_ff[0] != phase);
    wire last_edge = any_edge && (edge_ff == LAST_EDGE);

    wire data_wr = wr && hit_data;
    wire start_ctl = data_wr && enabled && is_ctrl && state_ff == ST_IDLE && !busy;
    wire load_ok = data_wr && !busy;
    wire mode_fault = enabled && is_ctrl && sel_as_input && !sel_s;
    wire sel_rise = sel_s && !sel_prev_ff;
    wire finish = last_edge;
    // A controller reply crosses the clock pin register and the synchroniser before it can be read,
    // so the controller's receive side trails its own edges; without this the fast rates read stale bits
    wire ctl_smp = sample_edge && (state_ff == ST_CTRL);
    wire ctl_fin = finish && (state_ff == ST_CTRL);
    wire rx_take = lag_smp_ff[MISO_LAG-1] || (sample_edge && state_ff == ST_TGT);
    wire rx_end = lag_fin_ff[MISO_LAG-1] || (finish && state_ff == ST_TGT);
    wire rx_bit = lag_smp_ff[MISO_LAG-1] ? miso_s : mosi_s;
    wire [7:0] rx_shifted = lsb_first ? {rx_bit, rx_sh_ff[7:1]} : {rx_sh_ff[6:0], rx_bit};
    wire set_done = rx_end || mode_fault;
    wire clr_flags = armed_ff && access && hit_data;

    // APB slave: one wait-free access cycle after setup
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end
        else if (clk_en)
        begin
            pready_ff <= setup_ph;
            pslverr_ff <= setup_ph && !mapped;
            if (setup_ph && !pwrite)
            begin
                prdata_ff <= hit_ctrl ? {24'h00_0000, ctrl_ff} :
                             hit_stat ? {24'h00_0000, done_ff, wcol_ff, 5'h00, double_ff} :
                             hit_data ? {24'h00_0000, rx_buf_ff} :
                             hit_pins ? {26'h000_0000, pcfg_ff} : 32'h0000_0000;
            end
        end
    end

    // Software registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_ff <= CTRL_RST;
            pcfg_ff <= PINS_RST;
            double_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            if (wr && hit_ctrl)
            begin
                ctrl_ff <= pwdata[7:0];
            end
            else if (mode_fault)
            begin
                ctrl_ff[CB_CTRL_SEL] <= 1'b0;
            end
            if (wr && hit_pins)
            begin
                pcfg_ff <= pwdata[PINS_W-1:0];
            end
            if (wr && hit_stat)
            begin
                double_ff <= pwdata[SB_DOUBLE];
            end
        end
    end

    // Flags: a setting event wins over the clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            done_ff <= 1'b0;
            wcol_ff <= 1'b0;
            armed_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            if (set_done)
            begin
                done_ff <= 1'b1;
            end
            else if (clr_flags)
            begin
                done_ff <= 1'b0;
            end
            if (data_wr && busy)
            begin
                wcol_ff <= 1'b1;
            end
            else if (clr_flags)
            begin
                wcol_ff <= 1'b0;
            end
            if (rd && hit_stat && done_ff)
            begin
                armed_ff <= 1'b1;
            end
            else if (access && hit_data)
            begin
                armed_ff <= 1'b0;
            end
        end
    end

    // Shift engine shared by both modes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_ff <= ST_IDLE;
            shift_ff <= 8'h00;
            rx_buf_ff <= 8'h00;
            out_bit_ff <= 1'b0;
            edge_ff <= 5'd0;
            div_ff <= 8'd0;
            sck_gen_ff <= 1'b0;
            sck_prev_ff <= 1'b1;
            sel_prev_ff <= 1'b1;
            rx_sh_ff <= 8'h00;
            lag_smp_ff <= '0;
            lag_fin_ff <= '0;
        end
        else if (clk_en)
        begin
            sck_prev_ff <= sck_s;
            sel_prev_ff <= sel_s;
            if (load_ok)
            begin
                shift_ff <= pwdata[7:0];
                out_bit_ff <= lsb_first ? pwdata[0] : pwdata[7];
            end
            case (state_ff)
                ST_IDLE:
                begin
                    sck_gen_ff <= idle_lvl;
                    edge_ff <= 5'd0;
                    if (start_ctl)
                    begin
                        state_ff <= ST_CTRL;
                        div_ff <= half_div;
                    end
                    else if (enabled && !is_ctrl && !sel_s)
                    begin
                        state_ff <= ST_TGT;
                        out_bit_ff <= head_bit;
                    end
                end
                ST_CTRL:
                begin
                    if (!enabled || mode_fault)
                    begin
                        state_ff <= ST_IDLE;
                    end
                    else if (ctl_edge)
                    begin
                        sck_gen_ff <= !sck_gen_ff;
                        div_ff <= half_div;
                        edge_ff <= edge_ff + 5'd1;
                    end
                    else
                    begin
                        div_ff <= div_ff - 8'd1;
                    end
                    if (finish)
                    begin
                        state_ff <= ST_IDLE;
                        sck_gen_ff <= idle_lvl;
                    end
                end
                ST_TGT:
                begin
                    if (!enabled || is_ctrl || sel_rise)
                    begin
                        state_ff <= ST_IDLE;
                    end
                    else if (tgt_edge)
                    begin
                        edge_ff <= finish ? 5'd0 : edge_ff + 5'd1;
                    end
                end
                default:
                begin
                    state_ff <= ST_IDLE;
                end
            endcase
            if (sample_edge)
            begin
                shift_ff <= shifted;
            end
            if (setup_edge)
            begin
                out_bit_ff <= head_bit;
            end
            lag_smp_ff <= {lag_smp_ff[MISO_LAG-2:0], ctl_smp};
            lag_fin_ff <= {lag_fin_ff[MISO_LAG-2:0], ctl_fin};
            if (rx_take)
            begin
                rx_sh_ff <= rx_shifted;
            end
            if (rx_end)
            begin
                rx_buf_ff <= rx_take ? rx_shifted : rx_sh_ff;
            end
        end
    end

    // Pin directions and levels; select is only ever driven from software's level bit
    wire ctl_on = enabled && is_ctrl;
    wire tgt_on = enabled && !is_ctrl && !sel_s;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pins_ff <= '0;
            irq_ff <= 1'b0;
            wake_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            pins_ff.mosi_o <= out_bit_ff;
            pins_ff.mosi_oe <= ctl_on && pcfg_ff[PB_MOSI_DIR];
            pins_ff.miso_o <= out_bit_ff;
            pins_ff.miso_oe <= tgt_on && pcfg_ff[PB_MISO_DIR];
            pins_ff.sck_o <= (state_ff == ST_CTRL) ? sck_gen_ff : idle_lvl;
            pins_ff.sck_oe <= ctl_on && pcfg_ff[PB_SCK_DIR];
            pins_ff.sel_o <= pcfg_ff[PB_SEL_LEVEL];
            pins_ff.sel_oe <= ctl_on && pcfg_ff[PB_SEL_DIR];
            irq_ff <= (done_ff || set_done) && ctrl_ff[CB_IRQ_EN];
            wake_ff <= set_done;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign pins = pins_ff;
    assign irq = irq_ff;
    assign wake = wake_ff;
endmodule

// ===== verification/spi_target_model.sv
// Behavioural far-side target used while the port is the controller
`timescale 1ns/1ps
module spi_target_model
(
    input wire logic sck,
    input wire logic sel_n,
    input wire logic mosi,
    input wire logic [1:0] mode,
    input wire logic [7:0] tx_byte,
    output logic miso,
    output logic [7:0] rx_byte
);
    logic [7:0] sh;
    task automatic put();
        miso = sh[7];
        sh = {sh[6:0], 1'b0};
    endtask
    initial
    begin
        miso = 1'b0;
        rx_byte = 8'h00;
    end
    // Packet restarts on every select fall
    always @(negedge sel_n)
    begin
        sh = tx_byte;
        if (!mode[0])
            put();
    end
    // Released line shows the inverse of its last bit, never a stale one
    always @(posedge sel_n)
        miso = ~miso;
    // Leading edge samples for phase 0, trailing for phase 1
    always @(sck)
        if (!sel_n)
        begin
            if ((sck != mode[1]) != mode[0])
                rx_byte = {rx_byte[6:0], mosi};
            else
                put();
        end
endmodule

// ===== verification/ssp_properties.sv
// Bus and pin checks for the serial shift port
`timescale 1ns/1ps
module ssp_properties
    import ssp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic sel_n_i,
    input wire pin_out_t pins,
    input wire logic irq,
    input wire logic wake
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ready_after_setup_a: assert property (psel && !penable |=> pready) else $error("ready late");
    ready_in_access_a: assert property (pready |-> psel && penable) else $error("ready outside access");
    unmapped_refused_a: assert property (pready && paddr > OFS_PINS |-> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access");
    upper_bits_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0) else $error("upper bits");
    // Select is synchronised, so allow its settle before judging
    miso_quiet_a: assert property (sel_n_i [*4] |-> !pins.miso_oe) else $error("miso driven");
    pin_dir_a: assert property (pins.miso_oe |-> !pins.mosi_oe && !pins.sck_oe && !pins.sel_oe)
        else $error("pin directions");
    reset_quiet_a: assert property ($rose(presetn) |-> pins == '0 && !irq && !wake)
        else $error("outputs after reset");
    wake_pulse_a: assert property (wake |=> !wake) else $error("wake too long");
    sck_rest_a: assert property (wake |=> $stable(pins.sck_o) [*2]) else $error("clock not stopped");
endmodule
bind sync_serial_shift_port ssp_properties ssp_properties_inst (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .prdata, .pready, .pslverr, .sel_n_i, .pins, .irq, .wake);

// ===== verification/sync_serial_shift_port_tb.sv
// Self-checking bench for the serial shift port
`timescale 1ns/1ps
module sync_serial_shift_port_tb;
    import ssp_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic pready, pslverr, irq, wake, slv;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    pin_out_t pins;
    logic tb_sck = 1'b0, tb_sel_n = 1'b1, tb_mosi = 1'b0, m_miso, sck_w, sel_w, mosi_w, miso_w;
    logic [1:0] mmode = 2'b00;
    logic [7:0] mtx = 8'h00, mrx, got;
    int err_total = 0, n_tests = 0;
    int divs[4] = '{DIV_R0, DIV_R1, DIV_R2, DIV_R3};
    time t1 = 0, t2 = 0;
    // Undriven lines fall back to what the bench drives, select idling high
    assign sck_w = pins.sck_oe ? pins.sck_o : tb_sck;
    assign sel_w = pins.sel_oe ? pins.sel_o : tb_sel_n;
    assign mosi_w = pins.mosi_oe ? pins.mosi_o : tb_mosi;
    assign miso_w = pins.miso_oe ? pins.miso_o : m_miso;
    sync_serial_shift_port sync_serial_shift_port_inst (.pclk, .presetn, .clk_en(1'b1), .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .mosi_i(mosi_w), .miso_i(miso_w), .sck_i(sck_w),
        .sel_n_i(sel_w), .pins, .irq, .wake);
    spi_target_model spi_target_model_inst (.sck(sck_w), .sel_n(sel_w), .mosi(mosi_w), .mode(mmode),
        .tx_byte(mtx), .miso(m_miso), .rx_byte(mrx));
    initial
    begin
        forever #20 pclk = ~pclk;
    end
    always @(pins.sck_o)
    begin
        t1 = t2;
        t2 = $time;
    end
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e)
        begin
            err_total++;
            $display("mismatch at %0t got %h expected %h", $time, g, e);
        end
    endtask
    function automatic logic [7:0] rev(input logic [7:0] v);
        for (int k = 0; k < 8; k++)
            rev[k] = v[7 - k];
    endfunction
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Answer is taken at the rising edge that finds pready high
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic do_reset();
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
    endtask
    task automatic wait_done();
        do
            apb(OFS_STAT, 1'b0, 32'h0);
        while (rd[SB_DONE] !== 1'b1);
    endtask
    // Bench acts as far controller: half periods of four clocks, mode 0
    task automatic shift(input logic [7:0] b, input int nb);
        for (int k = 0; k < nb; k++)
        begin
            tb_mosi <= b[7 - k];
            repeat (4) @(posedge pclk);
            tb_sck <= 1'b1;
            repeat (4) @(posedge pclk);
            // The port answers an edge several clocks late, so its bit is read at the end of the high phase
            got = {got[6:0], miso_w};
            tb_sck <= 1'b0;
        end
        repeat (4) @(posedge pclk);
    endtask
    task automatic t_reset();
        apb(OFS_CTRL, 1'b0, 32'h0);
        chk(rd, {24'h0, CTRL_RST});
        apb(OFS_STAT, 1'b0, 32'h0);
        chk(rd, 32'h0);
        apb(OFS_DATA, 1'b0, 32'h0);
        chk(rd, 32'h0);
        apb(OFS_PINS, 1'b0, 32'h0);
        chk(rd, {26'h0, PINS_RST});
        apb(8'h10, 1'b1, 32'hff);
        chk(slv, 1'b1);
        apb(8'h10, 1'b0, 32'h0);
        chk(slv, 1'b1);
        chk(rd, 32'h0);
        apb(OFS_CTRL, 1'b1, 32'h50);
        apb(OFS_PINS, 1'b1, 32'h0f);
        apb(OFS_DATA, 1'b1, 32'h11);
        repeat (40) @(posedge pclk);
        apb(OFS_STAT, 1'b0, 32'h0);
        chk(rd, 32'h0);
        chk(pins.sck_oe, 1'b0);
    endtask
    task automatic t_ctrl();
        int full;
        logic [7:0] d;
        for (int i = 0; i < 8; i++)
        begin
            d = 8'h35 + 8'(i * 29);
            mmode = 2'(i) ^ {i[2], 1'b0};
            mtx = ~d ^ 8'h0f;
            full = divs[i % 4] >> i[2];
            apb(OFS_CTRL, 1'b1, {24'h0, 2'b11, i[0], 1'b1, mmode, i[1:0]});
            apb(OFS_STAT, 1'b1, {31'h0, i[2]});
            apb(OFS_PINS, 1'b1, 32'h2e);
            apb(OFS_PINS, 1'b1, 32'h0e);
            apb(OFS_DATA, 1'b1, {24'h0, d});
            apb(OFS_DATA, 1'b1, {24'h0, ~d});
            wait_done();
            chk(rd, {24'h0, 2'b11, 5'h0, i[2]});
            chk(irq, 1'b1);
            chk(32'(t2 - t1), 32'(full * 20));
            chk(mrx, i[0] ? rev(d) : d);
            apb(OFS_DATA, 1'b0, 32'h0);
            chk(rd, {24'h0, i[0] ? rev(mtx) : mtx});
            apb(OFS_STAT, 1'b0, 32'h0);
            chk(rd, {31'h0, i[2]});
            apb(OFS_PINS, 1'b1, 32'h2e);
        end
    endtask
    task automatic t_fault();
        apb(OFS_CTRL, 1'b1, 32'h50);
        apb(OFS_PINS, 1'b1, 32'h06);
        tb_sel_n <= 1'b0;
        repeat (6) @(posedge pclk);
        apb(OFS_CTRL, 1'b0, 32'h0);
        chk(rd, 32'h40);
        apb(OFS_STAT, 1'b0, 32'h0);
        chk(rd, 32'h80);
        tb_sel_n <= 1'b1;
    endtask
    task automatic t_target();
        apb(OFS_CTRL, 1'b1, 32'hc0);
        apb(OFS_PINS, 1'b1, 32'h10);
        apb(OFS_DATA, 1'b1, 32'ha5);
        chk(pins.miso_oe, 1'b0);
        shift(8'hff, 4);
        tb_sel_n <= 1'b0;
        shift(8'h3c, 8);
        chk(got, 8'ha5);
        shift(8'h00, 3);
        chk(irq, 1'b1);
        tb_sel_n <= 1'b1;
        repeat (4) @(posedge pclk);
        apb(OFS_DATA, 1'b1, 32'h96);
        tb_sel_n <= 1'b0;
        shift(8'hc3, 8);
        chk(got, 8'h96);
        apb(OFS_DATA, 1'b0, 32'h0);
        chk(rd, 32'hc3);
        tb_sel_n <= 1'b1;
    endtask
    initial
    begin
        do_reset();
        t_reset();
        do_reset();
        t_ctrl();
        do_reset();
        t_fault();
        do_reset();
        t_target();
        stop_test();
    end
    initial
    begin
        #1000000;
        err_total++;
        stop_test();
    end
endmodule
